// >>> rtl/clkmul_pkg.sv
package clkmul_pkg;
  // register byte addresses on the avalon slave
  localparam logic [3:0] setup_two_offset   = 4'h0;
  localparam logic [3:0] command_offset     = 4'h4;
  localparam logic [3:0] status_offset      = 4'h8;
  localparam logic [3:0] strap_offset       = 4'hc;

  // setup_two_config field positions
  localparam int hs_read_bit     = 7;
  localparam int reserved_bit    = 6;
  localparam int mult_sel_lsb    = 4;
  localparam int enh_func_bit    = 3;
  localparam int low_field_msb   = 2;

  localparam logic [7:0] setup_two_reset = 8'h00;
  localparam logic [7:0] setup_two_wmask = 8'hbf;

  // multiplier select codes
  localparam logic [1:0] mult_20mhz    = 2'h0;
  localparam logic [1:0] mult_40mhz    = 2'h1;
  localparam logic [1:0] mult_reserved = 2'h2;
  localparam logic [1:0] mult_80mhz    = 2'h3;

  localparam logic [7:0] restart_cmd = 8'h18;

  // status register bit positions
  localparam int st_halted_bit   = 0;
  localparam int st_pll_pwr_bit  = 1;
  localparam int st_locked_bit   = 2;
  localparam int st_changed_bit  = 3;
  localparam int st_hs_read_bit  = 4;
  localparam int st_legacy_bit   = 5;
  localparam int st_strap_bit    = 6;

  // pll lock time, typical
  localparam int clk_mhz       = 125;
  localparam int lock_time_ns  = 8000;
  localparam int lock_cycles   = (lock_time_ns * clk_mhz) / 1000;
  localparam int lock_cnt_w    = 10;

  localparam logic [31:0] unmapped_read = 32'h00000000;

  typedef enum logic [1:0] {
    pll_off,
    pll_settling,
    pll_stable
  } pll_state_t;
endpackage

// >>> rtl/strap_sync.sv
`timescale 1ns/1ps
module strap_sync (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage feeds only the second; accept a change once stages 2 and 3 agree
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule

// >>> rtl/clock_multiplier_setup_control.sv
`timescale 1ns/1ps
// Overview of operation
// - fast read needs strap and select bit
// - write timing never follows select bit
// - bit 6 reserved, no function
// - select 00/01/11 gives 20/40/80 MHz
// - multiplier powered down until select changes
// - select change halts core, wakes pll
// - pll locks about 8 us after wake
// - enhanced bit resets 0, enables new functions
module clock_multiplier_setup_control
  import clkmul_pkg::*;
#(
  parameter int lock_count = lock_cycles
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        bus_timing_strap,
  output logic             high_speed_read_en,
  output logic             write_timing_fast,
  output logic [1:0]       clock_multiplier_select,
  output logic [2:0]       clock_freq_code,
  output logic             pll_power_up,
  output logic             pll_locked,
  output logic             core_halt,
  output logic             enhanced_function_enable,
  output logic             legacy_mode,
  output logic [2:0]       setup_two_low_bits
);
  logic [7:0]            setup_q;
  logic                  changed_q;
  logic                  halt_q;
  pll_state_t            pll_q;
  logic [lock_cnt_w-1:0] lock_cnt_q;
  logic                  rd_done_q;
  logic [31:0]           rdata_q;
  logic                  strap_q;
  logic                  wr_setup;
  logic                  wr_cmd;
  logic [1:0]            new_sel;
  logic                  sel_change;
  logic [7:0]            wr_byte;
  logic [7:0]            setup_d;
  logic [1:0]            cur_sel;
  logic                  restart_hit;
  logic                  lock_done;
  logic                  rd_start;
  logic [6:0]            status_word;
  logic [31:0]           rdata_d;

  strap_sync u_strap (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pin_in  (bus_timing_strap),
    .level_q (strap_q)
  );

  // writes finish in the cycle they are presented; reads take one wait cycle
  assign rd_start        = avs_read && !rd_done_q;
  assign avs_waitrequest = rd_start;
  assign wr_byte         = avs_writedata[7:0];
  assign wr_setup        = avs_write && avs_byteenable[0] && (avs_address == setup_two_offset);
  assign wr_cmd          = avs_write && avs_byteenable[0] && (avs_address == command_offset);
  assign restart_hit     = wr_cmd && (wr_byte == restart_cmd);
  assign cur_sel         = setup_q[mult_sel_lsb +: 2];
  assign new_sel         = wr_byte[mult_sel_lsb +: 2];
  // rewriting the same select is not a change and must not halt the core
  assign sel_change      = wr_setup && (new_sel != cur_sel);

  always_comb begin
    setup_d = setup_q;
    if (wr_setup) begin
      // reserved bit 6 never stored, reads back zero
      setup_d = wr_byte & setup_two_wmask;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      setup_q <= setup_two_reset;
    end else begin
      setup_q <= setup_d;
    end
  end

  // remembers a multiplier change since reset; repeat changes are the host's fault
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      changed_q <= 1'b0;
    end else if (sel_change) begin
      changed_q <= 1'b1;
    end
  end

  // change beats a restart written in the same cycle; a later restart resumes the core even while the pll is still settling
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      halt_q <= 1'b0;
    end else if (sel_change) begin
      halt_q <= 1'b1;
    end else if (restart_hit) begin
      halt_q <= 1'b0;
    end
  end

  // lock time is a cycle count only; no real pll feedback is modelled
  assign lock_done = (lock_cnt_q == lock_cnt_w'(lock_count - 1));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pll_q <= pll_off;
    end else if (sel_change) begin
      pll_q <= pll_settling;
    end else begin
      unique case (pll_q)
        pll_off: begin
          pll_q <= pll_off;
        end
        pll_settling: begin
          if (lock_done) begin
            pll_q <= pll_stable;
          end
        end
        pll_stable: begin
          pll_q <= pll_stable;
        end
      endcase
    end
  end

  // a fresh change restarts the lock wait from zero
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lock_cnt_q <= '0;
    end else if (sel_change) begin
      lock_cnt_q <= '0;
    end else if ((pll_q == pll_settling) && !lock_done) begin
      lock_cnt_q <= lock_cnt_q + lock_cnt_w'(1);
    end
  end

  always_comb begin
    status_word                 = '0;
    status_word[st_halted_bit]  = halt_q;
    status_word[st_pll_pwr_bit] = (pll_q != pll_off);
    status_word[st_locked_bit]  = (pll_q == pll_stable);
    status_word[st_changed_bit] = changed_q;
    status_word[st_hs_read_bit] = high_speed_read_en;
    status_word[st_legacy_bit]  = legacy_mode;
    status_word[st_strap_bit]   = strap_q;
  end

  // read data captured once per read and held until the next one
  always_comb begin
    rdata_d = rdata_q;
    if (rd_start) begin
      unique case (avs_address)
        setup_two_offset: rdata_d = {24'h000000, setup_q};
        status_offset:    rdata_d = {25'h0, status_word};
        default:          rdata_d = unmapped_read;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= rd_start;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_q <= unmapped_read;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  always_comb begin
    unique case (setup_q[mult_sel_lsb +: 2])
      mult_20mhz:    clock_freq_code = 3'h1;
      mult_40mhz:    clock_freq_code = 3'h2;
      mult_80mhz:    clock_freq_code = 3'h4;
      // reserved code: run off the crystal as at reset
      mult_reserved: clock_freq_code = 3'h1;
    endcase
  end

  assign high_speed_read_en       = strap_q && setup_q[hs_read_bit];
  // writes keep standard timing whatever the read select says
  assign write_timing_fast        = 1'b0;
  assign clock_multiplier_select  = setup_q[mult_sel_lsb +: 2];
  assign pll_power_up             = pll_q != pll_off;
  assign pll_locked               = pll_q == pll_stable;
  assign core_halt                = halt_q;
  assign enhanced_function_enable = setup_q[enh_func_bit];
  assign legacy_mode              = !setup_q[enh_func_bit];
  assign setup_two_low_bits       = setup_q[low_field_msb:0];
endmodule

// >>> bench/clock_multiplier_setup_control_properties.sv
`timescale 1ns/1ps
module setup_control_checker
  import clkmul_pkg::*;
#(
  parameter int lock_count = lock_cycles
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        bus_timing_strap,
  input wire logic        high_speed_read_en,
  input wire logic        write_timing_fast,
  input wire logic [1:0]  clock_multiplier_select,
  input wire logic [2:0]  clock_freq_code,
  input wire logic        pll_power_up,
  input wire logic        pll_locked,
  input wire logic        core_halt,
  input wire logic        enhanced_function_enable,
  input wire logic        legacy_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic        restart_w;
  logic [15:0] wait_q;
  assign restart_w = avs_write && avs_byteenable[0] && avs_address == command_offset
                     && avs_writedata[7:0] == restart_cmd;
  // cycles spent powered but unlocked
  always_ff @(posedge mclk) begin
    if (!reset_n || !pll_power_up || pll_locked) wait_q <= 16'h0;
    else wait_q <= wait_q + 16'h1;
  end
  chk_strap_gates_read: assert property ((!bus_timing_strap) [*6] |-> !high_speed_read_en)
    else $error("fast read on without strap");
  chk_write_timing_fixed: assert property (!write_timing_fast)
    else $error("write timing changed");
  chk_freq_code_map: assert property (clock_freq_code == (clock_multiplier_select == mult_80mhz
    ? 3'h4 : clock_multiplier_select == mult_40mhz ? 3'h2 : 3'h1))
    else $error("wrong frequency code");
  chk_pll_off_default: assert property (!pll_power_up |-> !pll_locked
    && clock_multiplier_select == mult_20mhz)
    else $error("pll active without change");
  chk_change_halts_core: assert property (clock_multiplier_select
    != $past(clock_multiplier_select) |-> core_halt && pll_power_up)
    else $error("change did not halt core");
  chk_lock_not_early: assert property ($rose(pll_locked) |-> wait_q >= lock_count - 2)
    else $error("pll locked early");
  chk_lock_not_late: assert property (wait_q <= lock_count + 1)
    else $error("pll lock late");
  chk_halt_held: assert property (core_halt && !restart_w |=> core_halt)
    else $error("core resumed without restart");
  chk_restart_resumes: assert property (restart_w |=> !core_halt)
    else $error("restart ignored");
  chk_legacy_inverse: assert property (legacy_mode == !enhanced_function_enable)
    else $error("legacy not inverse of enhanced");
endmodule
bind clock_multiplier_setup_control setup_control_checker #(.lock_count(lock_count)) chk (
  .mclk, .reset_n, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .bus_timing_strap, .high_speed_read_en, .write_timing_fast, .clock_multiplier_select,
  .clock_freq_code, .pll_power_up, .pll_locked, .core_halt, .enhanced_function_enable,
  .legacy_mode);

// >>> bench/clock_multiplier_setup_control_test.sv
`timescale 1ns/1ps
module clock_multiplier_setup_control_test import clkmul_pkg::*; ;
  logic        mclk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        bus_timing_strap = 1'b1, avs_waitrequest, high_speed_read_en, write_timing_fast;
  logic        pll_power_up, pll_locked, core_halt, enhanced_function_enable, legacy_mode;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [1:0]  clock_multiplier_select;
  logic [2:0]  clock_freq_code, setup_two_low_bits;
  logic [2:0]  fcode [4] = '{3'h1, 3'h2, 3'h1, 3'h4};
  int          miscompares = 0;
  int          check_count = 0;
  always #4 mclk = ~mclk;
  clock_multiplier_setup_control #(.lock_count(10)) dut (
    .mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .bus_timing_strap,
    .high_speed_read_en, .write_timing_fast, .clock_multiplier_select, .clock_freq_code,
    .pll_power_up, .pll_locked, .core_halt, .enhanced_function_enable, .legacy_mode,
    .setup_two_low_bits);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until a rising edge sees waitrequest low; returns at a falling edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n >= 20) miscompares++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic do_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h0);
    check(rd, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    rd_chk(setup_two_offset, 32'h0);
    check({pll_power_up, core_halt, legacy_mode, write_timing_fast}, 4'b0010);
    bus(1'b1, setup_two_offset, 8'h4f);
    rd_chk(setup_two_offset, 32'h0f);
    check({enhanced_function_enable, pll_power_up, high_speed_read_en, setup_two_low_bits},
          6'b100111);
    bus(1'b1, setup_two_offset, 8'h88);
    repeat (6) @(negedge mclk);
    check({high_speed_read_en, write_timing_fast}, 2'b10);
    @(posedge mclk) bus_timing_strap <= 1'b0;
    repeat (6) @(negedge mclk);
    check(high_speed_read_en, 1'b0);
    $display("test fields and fast read done");
    bus(1'b1, setup_two_offset, 8'h38);
    check({core_halt, pll_power_up, pll_locked, clock_freq_code}, 6'b110100);
    // settle wait scaled down with the shortened lock count
    repeat (12) @(negedge mclk);
    check(pll_locked, 1'b1);
    bus(1'b1, strap_offset, 8'h18);
    bus(1'b1, command_offset, 8'h17);
    check(core_halt, 1'b1);
    bus(1'b1, command_offset, restart_cmd);
    check(core_halt, 1'b0);
    rd_chk(setup_two_offset, 32'h38);
    rd_chk(status_offset, 32'h0000000e);
    rd_chk(strap_offset, 32'h0);
    $display("test multiplier done");
    // at most one select change per reset, as the host must
    for (int i = 0; i < 4; i++) begin
      do_reset();
      bus(1'b1, setup_two_offset, {2'b00, i[1:0], 4'h8});
      check(clock_freq_code, fcode[i]);
      check({core_halt, pll_power_up}, {2{i != 0}});
    end
    $display("test one change per reset done");
    do_reset();
    check({pll_power_up, core_halt, clock_freq_code}, 5'b00001);
    rd_chk(setup_two_offset, 32'h0);
    $display("test second reset done");
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule
